/* File: wdt_pkg.sv */
package wdt_pkg;

  // Register byte offsets; the control word has three write aliases.
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_CLR = 5'h04;
  localparam logic [4:0] OFS_SET = 5'h08;
  localparam logic [4:0] OFS_INV = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_MASK = 5'h14;

  // Clear key and control field layout.
  localparam logic [15:0] CLEAR_KEY = 16'h5743;
  localparam int KEY_LSB = 16;
  localparam int KEY_W = 16;
  localparam int ENABLE_BIT = 15;
  localparam int PS_LSB = 8;
  localparam int PS_W = 5;
  localparam int WIN_BIT = 0;

  // Boot configuration word fields.
  localparam int CFG_EN_BIT = 23;
  localparam int CFG_PS_LSB = 0;

  // Reset values.
  localparam logic ENABLE_RST = 1'b0;
  localparam logic WIN_RST = 1'b0;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;

  // Event bits of the status and mask registers.
  localparam int EV_W = 3;
  localparam int EV_TIMEOUT = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_WINDOW = 2;

  // Width of the watchdog tick counter.
  localparam int COUNT_W = 32;

endpackage

/* File: keyed_watchdog_timer.sv */
// Overview of operation
// - The counter advances only on rising edges of the low-power RC clock while enabled.
// - If the count reaches the end of the period without a clear, a device reset pulse is issued.
// - Writing the key 5743h into bits 31-16 of the control word clears the counter.
// - The period is two to the power of the postscale value, counted in RC clock ticks.
// - An expiry during Sleep or Idle raises a wake request instead of a reset.
// - Control bit 15 is the read-write enable bit, zero after reset.
// - The enable bit only matters while boot configuration bit 23 is zero; when set it forces on.
// - Bits 12-8 read the postscale value caught from the boot configuration at reset.
// - Control bit 0 is the read-write window mode bit, zero after reset.
// - Offsets 4h, 8h and Ch clear, set or toggle the control bits written as one.
// - Unimplemented control bits 14-13 and 7-1 read zero and ignore writes.
//
// The register addresses and the strobed register port were chosen for this implementation.
module keyed_watchdog_timer (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic low_power_rc_clock,
  input wire logic [31:0] boot_config_word_one,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  output logic device_reset,
  output logic wake_req,
  output logic irq
);

  logic enable_reg;
  logic enable_next;
  logic win_reg;
  logic win_next;
  logic [wdt_pkg::PS_W-1:0] ps_reg;
  logic [wdt_pkg::PS_W-1:0] ps_next;
  logic [wdt_pkg::COUNT_W-1:0] count_reg;
  logic [wdt_pkg::COUNT_W-1:0] count_next;
  logic rc_q_reg;
  logic rc_q_next;
  logic reset_reg;
  logic reset_next;
  logic wake_reg;
  logic wake_next;
  logic [wdt_pkg::EV_W-1:0] status_reg;
  logic [wdt_pkg::EV_W-1:0] status_next;
  logic [wdt_pkg::EV_W-1:0] mask_reg;
  logic [wdt_pkg::EV_W-1:0] mask_next;
  logic irq_reg;
  logic irq_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  logic [31:0] ctrl_cur;
  logic [31:0] ctrl_new;
  logic ctrl_wr;
  logic key_hit;
  logic enabled;
  logic tick;
  logic low_power;
  logic window_open;
  logic early_key;
  logic expire;
  logic [wdt_pkg::COUNT_W-1:0] limit;
  logic [wdt_pkg::COUNT_W-1:0] limit_m1;
  logic [wdt_pkg::EV_W-1:0] events;

  // Control word as software sees it; only the implemented fields are nonzero.
  always_comb begin
    ctrl_cur = 32'h0000_0000;
    ctrl_cur[wdt_pkg::ENABLE_BIT] = enable_reg;
    ctrl_cur[wdt_pkg::PS_LSB +: wdt_pkg::PS_W] = ps_reg;
    ctrl_cur[wdt_pkg::WIN_BIT] = win_reg;
  end

  // Alias decode; the key field never enters the stored bits, so it reads zero.
  always_comb begin
    ctrl_wr = 1'b0;
    ctrl_new = ctrl_cur;
    if (reg_wr) begin
      case (reg_addr)
        wdt_pkg::OFS_CTRL: begin
          ctrl_wr = 1'b1;
          ctrl_new = reg_wdata;
        end
        wdt_pkg::OFS_CLR: begin
          ctrl_wr = 1'b1;
          ctrl_new = ctrl_cur & ~reg_wdata;
        end
        wdt_pkg::OFS_SET: begin
          ctrl_wr = 1'b1;
          ctrl_new = ctrl_cur | reg_wdata;
        end
        wdt_pkg::OFS_INV: begin
          ctrl_wr = 1'b1;
          ctrl_new = ctrl_cur ^ reg_wdata;
        end
        default: begin
          ctrl_wr = 1'b0;
          ctrl_new = ctrl_cur;
        end
      endcase
    end
  end

  // Writable control bits; bits 14-13 and 7-1 have no storage at all.
  always_comb begin
    enable_next = enable_reg;
    win_next = win_reg;
    if (ctrl_wr) begin
      enable_next = ctrl_new[wdt_pkg::ENABLE_BIT];
      win_next = ctrl_new[wdt_pkg::WIN_BIT];
    end
  end

  // The postscaler is caught from the boot word while reset is held, then frozen.
  always_comb begin
    ps_next = ps_reg;
    if (sys_rst) begin
      ps_next = boot_config_word_one[wdt_pkg::CFG_PS_LSB +: wdt_pkg::PS_W];
    end
  end

  // Only a plain store at the base offset carries the key; aliases never clear.
  assign key_hit = reg_wr && (reg_addr == wdt_pkg::OFS_CTRL)
    && (reg_wdata[wdt_pkg::KEY_LSB +: wdt_pkg::KEY_W] == wdt_pkg::CLEAR_KEY);

  // The configuration fuse overrides the software enable bit.
  assign enabled = enable_reg | boot_config_word_one[wdt_pkg::CFG_EN_BIT];

  // The RC clock is far slower than core_clk, so its rising edge is found by sampling.
  assign tick = low_power_rc_clock && !rc_q_reg;
  assign rc_q_next = low_power_rc_clock;

  // Period in ticks; the window opens at half the period.
  assign limit = {{(wdt_pkg::COUNT_W-1){1'b0}}, 1'b1} << ps_reg;
  assign limit_m1 = limit - {{(wdt_pkg::COUNT_W-1){1'b0}}, 1'b1};
  assign window_open = count_reg >= (limit >> 1);
  assign low_power = sleep_mode | idle_mode;

  // A key in the same cycle as the final tick wins, so a timely clear is never punished.
  assign expire = enabled && tick && !key_hit && (count_reg == limit_m1);
  assign early_key = enabled && key_hit && win_reg && !window_open;

  // Tick counter.
  always_comb begin
    count_next = count_reg;
    if (!enabled) begin
      count_next = '0;
    end else if (key_hit || expire) begin
      count_next = '0;
    end else if (tick) begin
      count_next = count_reg + {{(wdt_pkg::COUNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Reset and wake pulses; a sleeping device is woken rather than reset on expiry, but an early key always resets.
  always_comb begin
    reset_next = (expire && !low_power) || early_key;
    wake_next = expire && low_power;
  end

  // Sticky events; a new event in the cycle of its write-one-clear survives.
  always_comb begin
    events = '0;
    events[wdt_pkg::EV_TIMEOUT] = expire && !low_power;
    events[wdt_pkg::EV_WAKE] = expire && low_power;
    events[wdt_pkg::EV_WINDOW] = early_key;
    status_next = status_reg;
    mask_next = mask_reg;
    if (reg_wr && reg_addr == wdt_pkg::OFS_STATUS) begin
      status_next = status_reg & ~reg_wdata[wdt_pkg::EV_W-1:0];
    end
    if (reg_wr && reg_addr == wdt_pkg::OFS_MASK) begin
      mask_next = reg_wdata[wdt_pkg::EV_W-1:0];
    end
    status_next = status_next | events;
    irq_next = |(status_next & mask_next);
  end

  // Read data stand for exactly the cycle after the strobe; unmapped reads are zero.
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        wdt_pkg::OFS_CTRL: rdata_next = ctrl_cur;
        wdt_pkg::OFS_STATUS: rdata_next = {29'h0, status_reg};
        wdt_pkg::OFS_MASK: rdata_next = {29'h0, mask_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Registers; the postscaler has no reset value of its own.
  always_ff @(posedge core_clk) begin
    ps_reg <= ps_next;
    if (sys_rst) begin
      enable_reg <= wdt_pkg::ENABLE_RST;
      win_reg <= wdt_pkg::WIN_RST;
      count_reg <= '0;
      rc_q_reg <= 1'b0;
      reset_reg <= 1'b0;
      wake_reg <= 1'b0;
      status_reg <= wdt_pkg::STATUS_RST;
      mask_reg <= wdt_pkg::MASK_RST;
      irq_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      enable_reg <= enable_next;
      win_reg <= win_next;
      count_reg <= count_next;
      rc_q_reg <= rc_q_next;
      reset_reg <= reset_next;
      wake_reg <= wake_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign device_reset = reset_reg;
  assign wake_req = wake_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence seq_key_write;
    reg_wr && reg_addr == wdt_pkg::OFS_CTRL
      && reg_wdata[31:16] == wdt_pkg::CLEAR_KEY;
  endsequence

  sequence seq_bad_key;
    reg_wr && reg_addr == wdt_pkg::OFS_CTRL
      && reg_wdata[31:16] != wdt_pkg::CLEAR_KEY;
  endsequence

  sequence seq_final_tick;
    enabled && tick && count_reg == limit_m1;
  endsequence

  AST_RC_ONLY: assert property (
    enabled && !tick && !key_hit |=> count_reg == $past(count_reg))
    else $error("count moved without an RC clock edge");

  AST_DISABLED_IDLE: assert property (
    !enabled |=> count_reg == '0)
    else $error("count not held at zero while disabled");

  AST_TIMEOUT_RESET: assert property (
    seq_final_tick ##0 (!key_hit && !low_power) |=> device_reset && !wake_req)
    else $error("no reset pulse after the final tick");

  AST_KEY_CLEARS: assert property (
    seq_key_write ##0 enabled |=> count_reg == '0 && !wake_req)
    else $error("key write did not clear the count");

  AST_PERIOD: assert property (
    device_reset && !$past(early_key) |-> $past(count_reg) == $past(limit) - 32'h1)
    else $error("time-out at the wrong count");

  AST_SLEEP_WAKE: assert property (
    seq_final_tick ##0 (!key_hit && low_power) |=> wake_req && !device_reset)
    else $error("expiry in low power did not wake");

  AST_ENABLE_WRITE: assert property (
    reg_wr && reg_addr == wdt_pkg::OFS_CTRL |=> enable_reg == $past(reg_wdata[15]))
    else $error("enable bit not written");

  AST_FUSE_FORCES: assert property (
    boot_config_word_one[23] && tick && !key_hit && count_reg != limit_m1
      |=> count_reg == $past(count_reg) + 32'h1)
    else $error("fuse did not force counting");

  AST_PS_FROZEN: assert property (
    !sys_rst ##1 !sys_rst |-> ps_reg == $past(ps_reg))
    else $error("postscaler changed outside reset");

  AST_WIN_WRITE: assert property (
    reg_wr && reg_addr == wdt_pkg::OFS_CTRL |=> win_reg == $past(reg_wdata[0]))
    else $error("window bit not written");

  AST_ALIAS_INV: assert property (
    reg_wr && reg_addr == wdt_pkg::OFS_INV && reg_wdata[15]
      |=> enable_reg != $past(enable_reg))
    else $error("invert alias did not toggle");

  AST_ALIAS_CLR: assert property (
    reg_wr && reg_addr == wdt_pkg::OFS_CLR && reg_wdata[0] |=> !win_reg)
    else $error("clear alias did not clear");

  AST_READ_ZERO: assert property (
    reg_rd && reg_addr == wdt_pkg::OFS_CTRL
      |=> reg_rdata[31:16] == 16'h0000 && reg_rdata[14:13] == 2'h0
      && reg_rdata[7:1] == 7'h00 && reg_rdata[12:8] == ps_reg)
    else $error("control read shows reserved or key bits");

  AST_BAD_KEY: assert property (
    seq_bad_key ##0 (enabled && !tick) |=> count_reg == $past(count_reg))
    else $error("non-key write changed the count");

  AST_EARLY_KEY: assert property (
    seq_key_write ##0 (enabled && win_reg && count_reg < (limit >> 1))
      |=> device_reset ##1 !device_reset)
    else $error("early key did not reset");

  // The registered level must match the registered status and mask in the same cycle.
  AST_IRQ_LEVEL: assert property (
    irq == |(status_reg & mask_reg))
    else $error("interrupt level wrong");

endmodule

/* File: testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic low_power_rc_clock = 1'b0;
  logic [31:0] boot_config_word_one = 32'h0000_0002;
  logic sleep_mode = 1'b0;
  logic idle_mode = 1'b0;
  logic device_reset;
  logic wake_req;
  logic irq;
  int err_count = 0;
  int n_tests = 0;
  int rst_seen = 0;
  int wake_seen = 0;
  logic [31:0] v;

  keyed_watchdog_timer u_keyed_watchdog_timer (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .low_power_rc_clock(low_power_rc_clock), .boot_config_word_one(boot_config_word_one),
    .sleep_mode(sleep_mode), .idle_mode(idle_mode), .device_reset(device_reset),
    .wake_req(wake_req), .irq(irq));

  // A 100 ns period gives the 10 MHz core clock.
  initial begin
    forever #50 core_clk = ~core_clk;
  end

  // Pulses are counted here so scenarios only compare totals, never exact edges.
  always @(posedge core_clk) begin
    if (device_reset === 1'b1) rst_seen <= rst_seen + 1;
    if (wake_req === 1'b1) wake_seen <= wake_seen + 1;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bus tasks are entered just after a rising edge and leave just after one.
  // A write lets one more edge pass, so a following strobe is never set in the same step.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask

  // Each tick is two cycles high and two low so the edge detector sees it once.
  task automatic tick(input int n);
    repeat (n) begin
      low_power_rc_clock <= 1'b1;
      repeat (2) @(posedge core_clk);
      low_power_rc_clock <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask

  // The irq level changes on the same edge as status; two edges still pass before looking.
  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge core_clk);
    #1 chk("irq", {31'h0, irq}, {31'h0, exp});
    @(posedge core_clk);
  endtask

  task automatic s_regs();
    rd(wdt_pkg::OFS_CTRL, v); chk("ctrl reset", v, 32'h0000_0200);
    rd(wdt_pkg::OFS_STATUS, v); chk("status reset", v, 32'h0000_0000);
    rd(wdt_pkg::OFS_MASK, v); chk("mask reset", v, 32'h0000_0000);
    rd(5'h18, v); chk("unmapped", v, 32'h0000_0000);
    wr(wdt_pkg::OFS_CTRL, 32'h0000_FFFF);
    rd(wdt_pkg::OFS_CTRL, v); chk("ctrl ones", v, 32'h0000_8201);
    wr(wdt_pkg::OFS_CLR, 32'h0000_8001);
    rd(wdt_pkg::OFS_CTRL, v); chk("clr alias", v, 32'h0000_0200);
    wr(wdt_pkg::OFS_SET, 32'h0000_8000);
    rd(wdt_pkg::OFS_CTRL, v); chk("set alias", v, 32'h0000_8200);
    wr(wdt_pkg::OFS_INV, 32'h0000_8001);
    rd(wdt_pkg::OFS_CTRL, v); chk("inv alias", v, 32'h0000_0201);
    wr(wdt_pkg::OFS_INV, 32'h0000_0001);
    rd(wdt_pkg::OFS_CTRL, v); chk("inv back", v, 32'h0000_0200);
  endtask

  task automatic s_timeout();
    tick(6);
    chk("disabled resets", rst_seen, 0);
    wr(wdt_pkg::OFS_SET, 32'h0000_8000);
    tick(3);
    chk("early resets", rst_seen, 0);
    tick(1);
    chk("timeout resets", rst_seen, 1);
    rd(wdt_pkg::OFS_STATUS, v); chk("status timeout", v, 32'h0000_0001);
    chk_irq(1'b0);
    wr(wdt_pkg::OFS_MASK, 32'h0000_0007);
    chk_irq(1'b1);
    wr(wdt_pkg::OFS_STATUS, 32'h0000_0001);
    chk_irq(1'b0);
    rd(wdt_pkg::OFS_STATUS, v); chk("status cleared", v, 32'h0000_0000);
  endtask

  // The non-key write lands with the count one short of the limit.
  task automatic s_key();
    tick(3);
    wr(wdt_pkg::OFS_CTRL, 32'h5743_8000);
    tick(3);
    chk("key restarts", rst_seen, 1);
    rd(wdt_pkg::OFS_CTRL, v); chk("key reads zero", v, 32'h0000_8200);
    wr(wdt_pkg::OFS_CTRL, 32'h1234_8000);
    tick(1);
    chk("bad key ignored", rst_seen, 2);
    rd(wdt_pkg::OFS_STATUS, v); chk("status bad key", v, 32'h0000_0001);
    wr(wdt_pkg::OFS_STATUS, 32'h0000_0007);
  endtask

  task automatic s_wake();
    sleep_mode <= 1'b1;
    tick(4);
    sleep_mode <= 1'b0;
    idle_mode <= 1'b1;
    tick(4);
    idle_mode <= 1'b0;
    chk("wake pulses", wake_seen, 2);
    chk("no reset asleep", rst_seen, 2);
    rd(wdt_pkg::OFS_STATUS, v); chk("status wake", v, 32'h0000_0002);
    chk_irq(1'b1);
    wr(wdt_pkg::OFS_STATUS, 32'h0000_0007);
    chk_irq(1'b0);
  endtask

  // Window set by alias first, since a key write with bit 0 sees the old window bit and is not early.
  task automatic s_window();
    wr(wdt_pkg::OFS_SET, 32'h0000_0001);
    wr(wdt_pkg::OFS_CTRL, 32'h5743_8001);
    tick(1);
    chk("early key resets", rst_seen, 3);
    rd(wdt_pkg::OFS_STATUS, v); chk("status window", {31'h0, v[2]}, 32'h0000_0001);
    tick(1);
    wr(wdt_pkg::OFS_CTRL, 32'h5743_8001);
    tick(1);
    chk("open key accepted", rst_seen, 3);
    wr(wdt_pkg::OFS_STATUS, 32'h0000_0007);
    wr(wdt_pkg::OFS_CLR, 32'h0000_8001);
  endtask

  // Postscale bits change too, but must stay as caught during reset.
  task automatic s_fuse();
    boot_config_word_one <= 32'h0080_0005;
    tick(4);
    chk("fuse forces on", rst_seen, 4);
    rd(wdt_pkg::OFS_CTRL, v); chk("ps frozen", v, 32'h0000_0200);
    boot_config_word_one <= 32'h0000_0005;
    tick(4);
    chk("fuse off", rst_seen, 4);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    s_regs();
    s_timeout();
    s_key();
    s_wake();
    s_window();
    s_fuse();
    tally_and_finish();
  end

  // The whole run needs well under a thousand cycles; this is far beyond it.
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    tally_and_finish();
  end
endmodule
